// File: design/sps_sequencer.v
// Summary of operation
// [RULE1] The host keeps shutdown low until both supplies are stable before releasing it.
// [RULE2] The host makes the fast clock stable within 20 ms of shutdown release.
// [RULE3] The host makes the slow clock stable within 2 ms of shutdown release.
// [RULE4] The device drives request-to-send low within 100 ms of shutdown release; here it falls one clock after the 100 ms power-up.
// [RULE5] The host treats a request-to-send that never falls as a failed power-up.
// [RULE6] While shutdown is low the device sits in ultra-low power with all logic reset.
// [RULE7] The host holds shutdown low for at least 5 ms when it resets the device.
// [RULE8] In shutdown and power-up every pad is high impedance with its pull enabled.
// [RULE9] In active and deep sleep the serial and audio pads take their fixed directions and pulls.
// [RULE10] An undriven shutdown pin reads low through its pulldown, keeping shutdown.
// [RULE11] The host drives no non-fail-safe pad while the I/O supply is absent.
// [RULE12] The host times out on request-to-send after release and flags a failure.
`timescale 1ns/10ps
`include "sps_map.vh"

module sps_sequencer
#(
  parameter integer PWRUP_CYCLES = `SPS_PWRUP_MAX_MS * `SPS_MCLK_KHZ
)
(
  input  wire       i_mclk,
  input  wire       i_arst_n,
  input  wire       i_shutdown_low_in,
  input  wire       i_shutdown_low_in_driven,
  input  wire       i_io_supply_ok,
  input  wire       i_host_serial_receive,
  input  wire       i_host_serial_clear_to_send,
  input  wire       i_audio_bit_clock,
  input  wire       i_audio_frame_sync,
  input  wire       i_audio_serial_in,
  input  wire       i_core_serial_transmit,
  input  wire       i_core_rts_hold,
  input  wire       i_core_debug_trace,
  input  wire       i_core_deep_sleep_req,
  output wire       o_host_serial_receive_pu,
  output wire       o_host_serial_transmit,
  output wire       o_host_serial_transmit_oe,
  output wire       o_host_serial_transmit_pu,
  output wire       o_host_serial_request_to_send,
  output wire       o_host_serial_request_to_send_oe,
  output wire       o_host_serial_request_to_send_pu,
  output wire       o_host_serial_clear_to_send_pu,
  output wire       o_audio_bit_clock_pd,
  output wire       o_audio_frame_sync_pd,
  output wire       o_audio_serial_in_pd,
  output wire       o_audio_serial_out,
  output wire       o_audio_serial_out_oe,
  output wire       o_audio_serial_out_pd,
  output wire       o_debug_trace_out,
  output wire       o_debug_trace_out_oe,
  output wire       o_debug_trace_out_pu,
  output reg  [1:0] o_power_state,
  output reg        o_core_rst_n,
  output reg        o_core_serial_receive,
  output reg        o_core_clear_to_send,
  output reg        o_core_audio_bit_clock,
  output reg        o_core_audio_frame_sync,
  output reg        o_core_audio_serial_in
);

  // Power-up length equals the longest allowed time in clock cycles; the counter is 20 bits wide.
  localparam [31:0] PWRUP_LAST_W = PWRUP_CYCLES - 1;
  localparam [19:0] PWRUP_LAST   = PWRUP_LAST_W[19:0];

  // Pad configuration masks, one bit per pad, picked apart by the generate loop below.
  localparam [`SPS_NUM_PADS-1:0] SD_PU_M  = `SPS_SD_PU_MASK;
  localparam [`SPS_NUM_PADS-1:0] SD_PD_M  = `SPS_SD_PD_MASK;
  localparam [`SPS_NUM_PADS-1:0] ACT_OE_M = `SPS_ACT_OE_MASK;
  localparam [`SPS_NUM_PADS-1:0] ACT_PU_M = `SPS_ACT_PU_MASK;
  localparam [`SPS_NUM_PADS-1:0] ACT_PD_M = `SPS_ACT_PD_MASK;
  localparam [`SPS_NUM_PADS-1:0] SLP_OE_M = `SPS_SLP_OE_MASK;
  localparam [`SPS_NUM_PADS-1:0] SLP_PU_M = `SPS_SLP_PU_MASK;
  localparam [`SPS_NUM_PADS-1:0] SLP_PD_M = `SPS_SLP_PD_MASK;

  reg        rst_meta;
  reg        rst_sync;
  reg [19:0] pwrup_cnt;
  reg [1:0]  next_state;
  reg        rts_level;
  reg        rts_pin;
  wire       shutdown_released;
  wire [`SPS_NUM_PADS-1:0] pad_drive;
  wire [`SPS_NUM_PADS-1:0] pad_out;
  wire [`SPS_NUM_PADS-1:0] pad_oe;
  wire [`SPS_NUM_PADS-1:0] pad_pu;
  wire [`SPS_NUM_PADS-1:0] pad_pd;

  // Returns true when the pad bank must be in its shutdown arrangement.
  function is_quiet;
    input [1:0] state;
    begin
      is_quiet = (state == `SPS_ST_SHUTDOWN) || (state == `SPS_ST_POWERUP);
    end
  endfunction

  // Releases the asynchronous reset through two flip-flops.
  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_meta <= 1'h0;
      rst_sync <= 1'h0;
    end
    else
    begin
      rst_meta <= 1'h1;
      rst_sync <= rst_meta;
    end
  end

  // A floating shutdown pin counts as low because of its pulldown.
  assign shutdown_released = i_shutdown_low_in_driven & i_shutdown_low_in;  // [RULE10]

  // Chooses the next power state; shutdown low overrides everything.
  always @*
  begin
    next_state = o_power_state;
    if (!shutdown_released)
      next_state = `SPS_ST_SHUTDOWN;  // [RULE6]
    else
    begin
      case (o_power_state)
        `SPS_ST_SHUTDOWN:
          next_state = `SPS_ST_POWERUP;
        `SPS_ST_POWERUP:
          if (pwrup_cnt == PWRUP_LAST)
            next_state = `SPS_ST_ACTIVE;  // [RULE4]
        `SPS_ST_ACTIVE:
          if (i_core_deep_sleep_req)
            next_state = `SPS_ST_DEEP_SLEEP;
        `SPS_ST_DEEP_SLEEP:
          if (!i_core_deep_sleep_req)
            next_state = `SPS_ST_ACTIVE;
        default:
          next_state = `SPS_ST_SHUTDOWN;
      endcase
    end
  end

  // Holds state, the power-up timer and the core reset.
  always @(posedge i_mclk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      o_power_state <= `SPS_ST_SHUTDOWN;
      pwrup_cnt     <= 20'h00000;
      o_core_rst_n  <= 1'h0;
    end
    else
    begin
      o_power_state <= next_state;
      if (o_power_state == `SPS_ST_POWERUP && next_state == `SPS_ST_POWERUP)
        pwrup_cnt <= pwrup_cnt + 20'h00001;
      else
        pwrup_cnt <= 20'h00000;
      o_core_rst_n <= ~is_quiet(next_state);  // [RULE6]
    end
  end

  // Request-to-send sits high by default and follows i_core_rts_hold once power-up completes.
  always @*
  begin
    rts_level = 1'h1;
    if (!is_quiet(o_power_state))
      rts_level = i_core_rts_hold;  // [RULE4]
  end

  // Registers the request-to-send pin in one flop; it reads high whenever the pad is undriven.
  always @(posedge i_mclk or negedge rst_sync)
  begin
    if (!rst_sync)
      rts_pin <= 1'h1;
    else
      rts_pin <= rts_level | is_quiet(next_state);  // [RULE4]
  end

  // Output values offered to the pad bank.
  assign pad_drive = {i_core_debug_trace & (o_power_state == `SPS_ST_ACTIVE),
                      1'h0, 3'h0, 1'h1, rts_level, i_core_serial_transmit, 1'h1};

  // Builds one registered pad controller per pin.
  genvar gi;
  generate
    for (gi = 0; gi < `SPS_NUM_PADS; gi = gi + 1)
    begin : g_pad
      sps_pad
      #(
        .SD_PU  (SD_PU_M[gi]),
        .SD_PD  (SD_PD_M[gi]),
        .ACT_OE (ACT_OE_M[gi]),
        .ACT_PU (ACT_PU_M[gi]),
        .ACT_PD (ACT_PD_M[gi]),
        .SLP_OE (SLP_OE_M[gi]),
        .SLP_PU (SLP_PU_M[gi]),
        .SLP_PD (SLP_PD_M[gi])
      )
      u_pad
      (
        .i_mclk         (i_mclk),
        .i_rst_n        (rst_sync),
        .i_state        (next_state),
        .i_io_supply_ok (i_io_supply_ok),
        .i_drive        (pad_drive[gi]),
        .o_out          (pad_out[gi]),
        .o_oe           (pad_oe[gi]),
        .o_pu           (pad_pu[gi]),
        .o_pd           (pad_pd[gi])
      );
    end
  endgenerate

  // Maps the pad bank onto the named pins; every bit except request-to-send, which comes from rts_pin, comes from a pad flop.
  assign o_host_serial_receive_pu         = pad_pu[`SPS_PAD_RX];    // [RULE9]
  assign o_host_serial_transmit           = pad_out[`SPS_PAD_TX];   // [RULE9]
  assign o_host_serial_transmit_oe        = pad_oe[`SPS_PAD_TX];
  assign o_host_serial_transmit_pu        = pad_pu[`SPS_PAD_TX];
  assign o_host_serial_request_to_send    = rts_pin;
  assign o_host_serial_request_to_send_oe = pad_oe[`SPS_PAD_RTS];
  assign o_host_serial_request_to_send_pu = pad_pu[`SPS_PAD_RTS];
  assign o_host_serial_clear_to_send_pu   = pad_pu[`SPS_PAD_CTS];   // [RULE9]
  assign o_audio_bit_clock_pd             = pad_pd[`SPS_PAD_ACLK];  // [RULE9]
  assign o_audio_frame_sync_pd            = pad_pd[`SPS_PAD_AFSYNC];
  assign o_audio_serial_in_pd             = pad_pd[`SPS_PAD_AIN];
  assign o_audio_serial_out               = pad_out[`SPS_PAD_AOUT];
  assign o_audio_serial_out_oe            = pad_oe[`SPS_PAD_AOUT];
  assign o_audio_serial_out_pd            = pad_pd[`SPS_PAD_AOUT];
  assign o_debug_trace_out                = pad_out[`SPS_PAD_DBG];
  assign o_debug_trace_out_oe             = pad_oe[`SPS_PAD_DBG];
  assign o_debug_trace_out_pu             = pad_pu[`SPS_PAD_DBG];

  // Passes pad inputs to the core only when the pads are live; else idle levels.
  always @(posedge i_mclk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      o_core_serial_receive   <= 1'h1;
      o_core_clear_to_send    <= 1'h1;
      o_core_audio_bit_clock  <= 1'h0;
      o_core_audio_frame_sync <= 1'h0;
      o_core_audio_serial_in  <= 1'h0;
    end
    else if (is_quiet(next_state))
    begin
      o_core_serial_receive   <= 1'h1;
      o_core_clear_to_send    <= 1'h1;
      o_core_audio_bit_clock  <= 1'h0;
      o_core_audio_frame_sync <= 1'h0;
      o_core_audio_serial_in  <= 1'h0;
    end
    else
    begin
      o_core_serial_receive   <= i_host_serial_receive;  // [RULE9]
      o_core_clear_to_send    <= i_host_serial_clear_to_send;
      o_core_audio_bit_clock  <= i_audio_bit_clock;
      o_core_audio_frame_sync <= i_audio_frame_sync;
      o_core_audio_serial_in  <= i_audio_serial_in;
    end
  end

endmodule

// File: design/sps_map.vh
`ifndef SPS_MAP_VH
`define SPS_MAP_VH

// Power states reported on the power_state output.
`define SPS_ST_SHUTDOWN   2'h0
`define SPS_ST_POWERUP    2'h1
`define SPS_ST_ACTIVE     2'h2
`define SPS_ST_DEEP_SLEEP 2'h3

// Clock rate and power-up completion time.
`define SPS_MCLK_KHZ      10000
`define SPS_PWRUP_MAX_MS  100

// Pad indices inside the nine-pad bank.
`define SPS_PAD_RX        0
`define SPS_PAD_TX        1
`define SPS_PAD_RTS       2
`define SPS_PAD_CTS       3
`define SPS_PAD_ACLK      4
`define SPS_PAD_AFSYNC    5
`define SPS_PAD_AIN       6
`define SPS_PAD_AOUT      7
`define SPS_PAD_DBG       8
`define SPS_NUM_PADS      9

// Per-pad configuration masks, one bit per pad index.
`define SPS_SD_PU_MASK    9'h10F
`define SPS_SD_PD_MASK    9'h0F0
`define SPS_ACT_OE_MASK   9'h106
`define SPS_ACT_PU_MASK   9'h009
`define SPS_ACT_PD_MASK   9'h0F0
`define SPS_SLP_OE_MASK   9'h006
`define SPS_SLP_PU_MASK   9'h009
`define SPS_SLP_PD_MASK   9'h0F0

// Reset value of every pad output and output-enable flop.
`define SPS_PAD_RST_OUT   1'h0
`define SPS_PAD_RST_OE    1'h0

`endif

// File: design/sps_pad.v
`timescale 1ns/10ps
`include "sps_map.vh"

module sps_pad
#(
  parameter [0:0] SD_PU  = 1'h0,
  parameter [0:0] SD_PD  = 1'h0,
  parameter [0:0] ACT_OE = 1'h0,
  parameter [0:0] ACT_PU = 1'h0,
  parameter [0:0] ACT_PD = 1'h0,
  parameter [0:0] SLP_OE = 1'h0,
  parameter [0:0] SLP_PU = 1'h0,
  parameter [0:0] SLP_PD = 1'h0
)
(
  input  wire       i_mclk,
  input  wire       i_rst_n,
  input  wire [1:0] i_state,
  input  wire       i_io_supply_ok,
  input  wire       i_drive,
  output reg        o_out,
  output reg        o_oe,
  output reg        o_pu,
  output reg        o_pd
);

  reg next_oe;
  reg next_pu;
  reg next_pd;

  // Selects drive and pull settings from the power state.
  always @*
  begin
    case (i_state)
      `SPS_ST_ACTIVE:
      begin
        next_oe = ACT_OE;
        next_pu = ACT_PU;
        next_pd = ACT_PD;
      end
      `SPS_ST_DEEP_SLEEP:
      begin
        next_oe = SLP_OE;
        next_pu = SLP_PU;
        next_pd = SLP_PD;
      end
      default:
      begin
        next_oe = 1'h0;   // [RULE8]
        next_pu = SD_PU;  // [RULE8]
        next_pd = SD_PD;  // [RULE8]
      end
    endcase
  end

  // Registers the pad controls; pulls exist only while the I/O ring is powered.
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_out <= `SPS_PAD_RST_OUT;
      o_oe  <= `SPS_PAD_RST_OE;
      o_pu  <= SD_PU & 1'h0;
      o_pd  <= SD_PD & 1'h0;
    end
    else
    begin
      o_out <= i_drive & next_oe;
      o_oe  <= next_oe;
      o_pu  <= next_pu & i_io_supply_ok;  // [RULE8]
      o_pd  <= next_pd & i_io_supply_ok;  // [RULE8]
    end
  end

endmodule

// File: verification/sps_checker.sv
`timescale 1ns/10ps
module sps_checker
#(
  parameter integer PWRUP_CYCLES = 20
)
(
  input logic       i_mclk, i_arst_n, i_shutdown_low_in, i_shutdown_low_in_driven,
  input logic       i_io_supply_ok, i_core_rts_hold, o_core_rst_n,
  input logic       o_host_serial_request_to_send, o_host_serial_request_to_send_oe,
  input logic       o_host_serial_transmit_oe, o_debug_trace_out_oe, o_audio_serial_out_oe,
  input logic       o_host_serial_receive_pu, o_audio_bit_clock_pd,
  input logic [1:0] o_power_state
);
  logic [2:0] age;
  integer     cnt;
  wire  [1:0] st = o_power_state;
  wire        any_oe = o_host_serial_transmit_oe | o_host_serial_request_to_send_oe |
                       o_debug_trace_out_oe | o_audio_serial_out_oe;
  // Ages the reset release so pull checks skip the synchroniser delay; counts power-up cycles.
  always @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      age <= 3'h0;
      cnt <= 0;
    end
    else
    begin
      age <= (age == 3'h7) ? age : age + 3'h1;
      cnt <= (st == 2'h1) ? cnt + 1 : 0;
    end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  a_shutdown_resets_all: assert property (
    !(i_shutdown_low_in && i_shutdown_low_in_driven) |=> st == 2'h0 && !o_core_rst_n)
    else $error("device not in shutdown after low pin");
  a_quiet_pads_float: assert property (
    !st[1] |-> !any_oe && o_host_serial_request_to_send)
    else $error("pad driven during shutdown or power-up");
  a_pulls_follow_supply: assert property (
    age == 3'h7 |-> o_host_serial_receive_pu == $past(i_io_supply_ok) &&
    o_audio_bit_clock_pd == $past(i_io_supply_ok)) else $error("pull enable wrong");
  a_run_pad_dirs: assert property (
    st[1] |-> o_host_serial_transmit_oe && o_host_serial_request_to_send_oe &&
    !o_audio_serial_out_oe && o_debug_trace_out_oe == (st == 2'h2))
    else $error("pad direction wrong in active or sleep");
  a_powerup_bound: assert property (st == 2'h1 |-> cnt < PWRUP_CYCLES)
    else $error("power-up too long");
  a_powerup_exact: assert property (
    $past(st) == 2'h1 && st == 2'h2 |-> cnt == PWRUP_CYCLES) else $error("power-up length");
  a_rts_follows_hold: assert property (
    $past(st) == 2'h2 && st == 2'h2 |-> o_host_serial_request_to_send == $past(i_core_rts_hold))
    else $error("request-to-send wrong in active");
  a_core_reset_state: assert property (1'b1 |-> o_core_rst_n == st[1])
    else $error("core reset disagrees with state");
  a_sleep_from_run: assert property (st == 2'h3 |-> $past(st) >= 2'h2)
    else $error("deep sleep entered outside active");
  c_active: cover property (st == 2'h2);
  c_sleep: cover property (st == 2'h3);
  c_rts_low: cover property (o_host_serial_request_to_send_oe && !o_host_serial_request_to_send);
endmodule

bind sps_sequencer sps_checker #(.PWRUP_CYCLES(PWRUP_CYCLES)) u_chk (.*);

// File: verification/sps_host_model.sv
`timescale 1ns/10ps
// Host side: sequences supply and shutdown pin, and times out request-to-send.
module sps_host_model
#(
  parameter integer MIN_LOW = 8,
  parameter integer SETTLE  = 4,
  parameter integer TIMEOUT = 40
)
(
  input  logic i_mclk, i_arst_n, i_run, i_float, i_supply, i_rts, i_rx, i_cts,
  output logic o_shutdown_low_in, o_driven, o_io_supply_ok, o_fail, o_rx, o_cts
);
  logic   sd_q;
  integer low_cnt, sup_cnt, up_cnt;
  wire    released = o_driven & o_shutdown_low_in;
  // A floating pin shows a stray high level, so only the device's own pulldown keeps it
  // in shutdown; both clocks run stable from reset.
  assign o_shutdown_low_in = sd_q | i_float;
  assign o_driven = !i_float;
  assign o_io_supply_ok = i_supply;
  // Non-fail-safe pads carry data only with the supply; otherwise the model feeds the idle high level, since the device pulls are off.
  assign o_rx = i_supply ? i_rx : 1'b1;
  assign o_cts = i_supply ? i_cts : 1'b1;
  // Release only after settled supplies and the minimum low time; watch for completion.
  always @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      {sd_q, o_fail} <= 2'h0;
      {low_cnt, sup_cnt, up_cnt} <= '0;
    end
    else
    begin
      sup_cnt <= i_supply ? sup_cnt + (sup_cnt < SETTLE) : 0;
      if (!i_run || sup_cnt < SETTLE) sd_q <= 1'b0;
      else if (low_cnt >= MIN_LOW) sd_q <= 1'b1;
      low_cnt <= sd_q ? 0 : low_cnt + 1;
      up_cnt <= released ? up_cnt + 1 : 0;
      if (released && up_cnt == TIMEOUT && i_rts) o_fail <= 1'b1;
    end
endmodule

// File: verification/tb_sps_sequencer.sv
`timescale 1ns/10ps
module tb_sps_sequencer;
  localparam integer PW = 20;
  logic i_mclk, i_arst_n, i_shutdown_low_in, i_shutdown_low_in_driven, i_io_supply_ok;
  logic i_host_serial_receive, i_host_serial_clear_to_send, i_audio_bit_clock;
  logic i_audio_frame_sync, i_audio_serial_in, i_core_serial_transmit, i_core_rts_hold;
  logic i_core_debug_trace, i_core_deep_sleep_req, run, flt, sup, rx, cts, fail;
  logic o_host_serial_receive_pu, o_host_serial_transmit, o_host_serial_transmit_oe;
  logic o_host_serial_transmit_pu, o_host_serial_request_to_send, o_core_rst_n;
  logic o_host_serial_request_to_send_oe, o_host_serial_request_to_send_pu;
  logic o_host_serial_clear_to_send_pu, o_audio_bit_clock_pd, o_audio_frame_sync_pd;
  logic o_audio_serial_in_pd, o_audio_serial_out, o_audio_serial_out_oe, o_audio_serial_out_pd;
  logic o_debug_trace_out, o_debug_trace_out_oe, o_debug_trace_out_pu, o_core_serial_receive;
  logic o_core_clear_to_send, o_core_audio_bit_clock, o_core_audio_frame_sync;
  logic o_core_audio_serial_in;
  logic [1:0] o_power_state;
  logic [31:0] r;
  integer miscompares = 0, check_count = 0, cyc = 0, n;
  wire [12:0] pads = {o_host_serial_transmit_oe, o_host_serial_request_to_send_oe,
    o_debug_trace_out_oe, o_audio_serial_out_oe, o_host_serial_receive_pu,
    o_host_serial_transmit_pu, o_host_serial_request_to_send_pu, o_host_serial_clear_to_send_pu,
    o_debug_trace_out_pu, o_audio_bit_clock_pd, o_audio_frame_sync_pd, o_audio_serial_in_pd,
    o_audio_serial_out_pd};
  sps_sequencer #(.PWRUP_CYCLES(PW)) dut (.*);
  sps_host_model host (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_run(run), .i_float(flt),
    .i_supply(sup), .i_rts(o_host_serial_request_to_send), .i_rx(rx), .i_cts(cts),
    .o_shutdown_low_in(i_shutdown_low_in), .o_driven(i_shutdown_low_in_driven),
    .o_io_supply_ok(i_io_supply_ok), .o_fail(fail), .o_rx(i_host_serial_receive),
    .o_cts(i_host_serial_clear_to_send));
  // Expected pad output enables and pulls for a state and I/O supply level.
  function logic [12:0] exp_pads(input logic [1:0] st, input logic s);
    logic q;
    q = st < 2'h2;
    return {~q, ~q, st == 2'h2, 1'b0, s, s & q, s & q, s, s & q, s, s, s, s};
  endfunction
  // Compares one observed value with its expectation.
  task check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Waits on falling edges, with a bound, until the power state matches.
  task wait_st(input logic [1:0] st);
    n = 0;
    while (o_power_state !== st && n < 200)
    begin
      @(negedge i_mclk);
      n++;
    end
  endtask
  // Free-running clock and a cycle limit against hangs.
  initial
  begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      stop_test;
    end
  end
  // Main sequence: supply, power-up, random active traffic, sleep, shutdown, float, failure.
  initial
  begin
    {i_arst_n, run, flt, sup, i_audio_bit_clock, i_audio_frame_sync, i_audio_serial_in} = '0;
    {i_core_serial_transmit, i_core_rts_hold, i_core_debug_trace, i_core_deep_sleep_req} = '0;
    {rx, cts} = 2'h3;
    r = $urandom(53094);
    repeat (12) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    repeat (10) @(negedge i_mclk);
    check(pads, exp_pads(2'h0, 1'b0));
    @(posedge i_mclk) sup <= 1'b1;
    repeat (3) @(negedge i_mclk);
    check(pads, exp_pads(2'h0, 1'b1));
    @(posedge i_mclk) run <= 1'b1;
    wait_st(2'h1);
    check({pads, o_core_rst_n}, {exp_pads(2'h1, 1'b1), 1'b0});
    wait_st(2'h2);
    check(13'(n), 13'(PW));
    check(pads, exp_pads(2'h2, 1'b1));
    @(negedge i_mclk);
    check({o_host_serial_request_to_send, o_core_rst_n}, 2'b01);
    repeat (16)
    begin
      @(posedge i_mclk);
      r = $urandom;
      {i_core_debug_trace, i_core_rts_hold, i_core_serial_transmit, i_audio_serial_in,
        i_audio_frame_sync, i_audio_bit_clock, cts, rx} <= r[7:0];
      @(posedge i_mclk);
      @(negedge i_mclk);
      check({o_debug_trace_out, o_host_serial_request_to_send, o_host_serial_transmit,
        o_core_audio_serial_in, o_core_audio_frame_sync, o_core_audio_bit_clock,
        o_core_clear_to_send, o_core_serial_receive}, r[7:0]);
    end
    @(posedge i_mclk) i_core_deep_sleep_req <= 1'b1;
    repeat (2) @(negedge i_mclk);
    check({pads, o_power_state, o_audio_serial_out},
      {exp_pads(2'h3, 1'b1), 2'h3, 1'b0});
    @(posedge i_mclk) {run, i_core_deep_sleep_req} <= 2'h0;
    repeat (3) @(negedge i_mclk);
    check({pads, o_power_state}, {exp_pads(2'h0, 1'b1), 2'h0});
    @(posedge i_mclk) {run, flt, i_core_rts_hold} <= 3'h7;
    repeat (40) @(negedge i_mclk);
    check(o_power_state, 2'h0);
    @(posedge i_mclk) flt <= 1'b0;
    repeat (60) @(negedge i_mclk);
    check({fail, o_host_serial_request_to_send, o_power_state}, 4'hE);
    @(posedge i_mclk) sup <= 1'b0;
    repeat (4) @(negedge i_mclk);
    check({pads, o_power_state}, {exp_pads(2'h0, 1'b0), 2'h0});
    stop_test;
  end
endmodule
